/* hdl/psm_pkg.sv */
// constants and types shared by the supply switchover monitor
package psm_pkg;
    localparam int CLK_PERIOD_NS  = 25;          // sys_clk period, 40 MHz
    localparam int BUS_QUIET_NS   = 5_000_000;   // bus held inactive after backup, 5 ms
    localparam int BUS_QUIET_CYC  = (BUS_QUIET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WP_RECOVER_NS  = 5_000_000;   // write_protect_recovery_time, plain default
    localparam int WP_RECOVER_CYC = (WP_RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int REC_CNT_W      = 20;          // recovery counter width
    localparam int WEEK_SECONDS   = 604_800;     // one week of rtc second ticks
    localparam int WEEK_CNT_W     = 20;          // week counter width
    localparam int GPIO_N         = 2;           // number of general-purpose pins
    localparam logic [1:0] GPIO_RST = 2'h0;      // gpio reset value

    // supply modes
    typedef enum logic [1:0] {
        PSM_OFF,        // both supplies absent
        PSM_BACKUP,     // running from battery, rtc only
        PSM_RECOVER,    // main back, writes and bus blocked until each hold-off ends
        PSM_NORMAL      // main supply operation
    } psm_state_t;
endpackage

/* hdl/psm_gpio_if.sv */
// link between supply controller and gpio block
`timescale 1ns/1ps
`default_nettype none
interface psm_gpio_if;
    logic [psm_pkg::GPIO_N-1:0] dir;        // 1 = pin is output
    logic [psm_pkg::GPIO_N-1:0] out_val;    // value for output pins
    logic                       force_low;  // backup: pins low, inputs frozen
    logic [psm_pkg::GPIO_N-1:0] in_val;     // sampled input value

    modport ctl (output dir, output out_val, output force_low, input in_val);
    modport gp  (input dir, input out_val, input force_low, output in_val);
endinterface
`default_nettype wire

/* hdl/psm_gpio.sv */
// two general-purpose pins, each input or output
`timescale 1ns/1ps
`default_nettype none
module psm_gpio (
    input  wire logic                       sys_clk,   // system clock
    input  wire logic                       reset,     // async reset, active high
    psm_gpio_if.gp                          ctl,       // controller side
    input  wire logic [psm_pkg::GPIO_N-1:0] pin_i,     // pin level in
    output logic      [psm_pkg::GPIO_N-1:0] pin_o,     // pin level out
    output logic      [psm_pkg::GPIO_N-1:0] pin_oe     // pin drive enable
);
    import psm_pkg::*;

    logic [GPIO_N-1:0] s1_q, s2_q;      // input synchroniser
    logic [GPIO_N-1:0] in_q, in_d;      // held input value
    logic [GPIO_N-1:0] o_q, o_d;        // registered pin out
    logic [GPIO_N-1:0] oe_q, oe_d;      // registered enable

    // per pin next values
    for (genvar i = 0; i < GPIO_N; i++) begin : g_pin
        always_comb begin
            if (ctl.force_low) begin
                o_d[i]  = 1'b0;
                oe_d[i] = 1'b1;
                in_d[i] = in_q[i];
            end else begin
                o_d[i]  = ctl.out_val[i] & ctl.dir[i];
                oe_d[i] = ctl.dir[i];
                in_d[i] = ctl.dir[i] ? in_q[i] : s2_q[i];
            end
        end
    end

    // registers
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            s1_q <= GPIO_RST;
            s2_q <= GPIO_RST;
            in_q <= GPIO_RST;
            o_q  <= GPIO_RST;
            oe_q <= GPIO_RST;
        end else begin
            s1_q <= pin_i;
            s2_q <= s1_q;
            in_q <= in_d;
            o_q  <= o_d;
            oe_q <= oe_d;
        end
    end

    assign pin_o      = o_q;
    assign pin_oe     = oe_q;
    assign ctl.in_val = in_q;

    // output pin 0 follows its value
    gpio_drive_a: assert property (@(posedge sys_clk) disable iff (reset)
        (!ctl.force_low && ctl.dir[0]) |=> (pin_oe[0] && pin_o[0] == $past(ctl.out_val[0])))
        else $error("gpio0 output does not follow its value");
    // backup freezes inputs and grounds pins
    gpio_freeze_a: assert property (@(posedge sys_clk) disable iff (reset)
        ctl.force_low |=> ($stable(in_q) && pin_o == '0 && pin_oe == '1))
        else $error("gpio not frozen low in backup");
endmodule
`default_nettype wire

/* hdl/psm_top.sv */
// supply switchover, recovery hold-off and battery check controller
`timescale 1ns/1ps
`default_nettype none
module psm_top #(
    parameter int BUS_QUIET_CYCLES  = psm_pkg::BUS_QUIET_CYC,   // bus hold-off cycles
    parameter int WP_RECOVER_CYCLES = psm_pkg::WP_RECOVER_CYC,  // write hold-off cycles
    parameter int WEEK_TICKS        = psm_pkg::WEEK_SECONDS     // rtc ticks per recheck
) (
    input  wire logic                       sys_clk,              // 40 MHz clock
    input  wire logic                       reset,                // async reset, active high
    input  wire logic                       vcc_below_switchover, // cmp: vcc < 3.5 V
    input  wire logic                       vcc_below_battery,    // cmp: vcc < vbat
    input  wire logic                       battery_below_min,    // cmp: vbat < 2.5 V
    input  wire logic                       rtc_second_tick,      // rtc time base pulse
    input  wire logic                       battery_check_enable, // enable battery check
    input  wire logic                       irq_source_read,      // host read irq buffer
    input  wire logic [psm_pkg::GPIO_N-1:0] gpio_dir,             // 1 = output
    input  wire logic [psm_pkg::GPIO_N-1:0] gpio_out_val,         // output values
    input  wire logic [psm_pkg::GPIO_N-1:0] gpio_pin_i,           // gpio pin in
    output logic      [psm_pkg::GPIO_N-1:0] gpio_pin_o,           // gpio pin out
    output logic      [psm_pkg::GPIO_N-1:0] gpio_pin_oe,          // gpio drive enable
    output logic      [psm_pkg::GPIO_N-1:0] gpio_in_val,          // sampled inputs
    output logic                            irq_n_o,              // irq pin level, low
    output logic                            irq_n_oe,             // irq pin pull-down on
    output logic                            backup_mode,          // running from battery
    output logic                            shutdown,             // no supply at all
    output logic                            logic_power_en,       // core logic powered
    output logic                            rtc_power_en,         // rtc and oscillator powered
    output logic                            write_block,          // register writes blocked
    output logic                            bus_inactive          // serial bus held off
);
    import psm_pkg::*;

    localparam int DONE_CYC = (BUS_QUIET_CYCLES > WP_RECOVER_CYCLES) ?
                              BUS_QUIET_CYCLES : WP_RECOVER_CYCLES;

    psm_gpio_if gif ();                          // gpio control link

    logic [2:0] cs1_q, cs2_q;                    // comparator synchroniser
    logic       switchover_threshold, vbb, blow;                  // synchronised comparator levels
    psm_state_t state_q, state_d;                // supply mode
    logic [REC_CNT_W-1:0]  rec_q, rec_d;         // recovery counter
    logic [WEEK_CNT_W-1:0] week_q, week_d;       // weekly tick counter
    logic       pend_q, pend_d;                  // power-up check pending
    logic       irq_q, irq_d;                    // interrupt flag
    logic       chk_now;                         // check strobe this cycle
    logic       week_wrap;                       // week elapsed
    logic       bk_q, sd_q, lp_q, rp_q, wb_q, bi_q, oe_q;   // registered outputs
    logic       bk_d, sd_d, lp_d, rp_d, wb_d, bi_d, oe_d;   // their next values

    assign switchover_threshold  = cs2_q[0];
    assign vbb  = cs2_q[1];
    assign blow = cs2_q[2];

    // supply mode, counters and flags next state
    always_comb begin
        state_d = state_q;
        if (switchover_threshold && blow) begin
            state_d = PSM_OFF;
        end else begin
            case (state_q)
                PSM_OFF: begin
                    if (!vbb && !switchover_threshold) state_d = PSM_RECOVER;    // vcc up
                    else if (vbb && switchover_threshold) state_d = PSM_BACKUP;
                end
                PSM_BACKUP: begin
                    if (!vbb) state_d = PSM_RECOVER;
                end
                PSM_RECOVER: begin
                    if (switchover_threshold && vbb) state_d = PSM_BACKUP;
                    else if (32'(rec_q) >= DONE_CYC - 1) state_d = PSM_NORMAL;
                end
                PSM_NORMAL: begin
                    if (switchover_threshold && vbb) state_d = PSM_BACKUP;
                end
                default: state_d = PSM_OFF;
            endcase
        end
        // recovery counter runs only in recover mode
        rec_d = (state_q == PSM_RECOVER) ? rec_q + 1'b1 : '0;
        // weekly interval from rtc ticks, cleared in off mode or while the check is disabled, running in all other modes
        week_wrap = rtc_second_tick && (32'(week_q) == WEEK_TICKS - 1);
        if (!battery_check_enable || state_q == PSM_OFF) week_d = '0;
        else if (rtc_second_tick) week_d = week_wrap ? '0 : week_q + 1'b1;
        else week_d = week_q;
        // power-up check pending until normal mode first reached
        chk_now = (pend_q && state_d == PSM_NORMAL) ||
                  (week_wrap && battery_check_enable);
        pend_d  = (state_q == PSM_OFF) ? 1'b1 : (pend_q && state_d != PSM_NORMAL);
        // set beats clear; read ignored while inputs are off
        irq_d = irq_q;
        if (irq_source_read && state_q == PSM_NORMAL) irq_d = 1'b0;
        if (chk_now && battery_check_enable && blow) irq_d = 1'b1;
        // mode outputs
        bk_d = (state_d == PSM_BACKUP);
        sd_d = (state_d == PSM_OFF);
        lp_d = (state_d == PSM_RECOVER) || (state_d == PSM_NORMAL);
        rp_d = (state_d != PSM_OFF);
        wb_d = !((state_d == PSM_NORMAL) ||
                 (state_d == PSM_RECOVER && 32'(rec_d) >= WP_RECOVER_CYCLES));
        bi_d = !((state_d == PSM_NORMAL) ||
                 (state_d == PSM_RECOVER && 32'(rec_d) >= BUS_QUIET_CYCLES));
        oe_d = irq_d && lp_d;
    end

    // registers
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            cs1_q   <= 3'h0;
            cs2_q   <= 3'h0;
            state_q <= PSM_OFF;
            rec_q   <= '0;
            week_q  <= '0;
            pend_q  <= 1'b1;
            irq_q   <= 1'b0;
            bk_q    <= 1'b0;
            sd_q    <= 1'b1;
            lp_q    <= 1'b0;
            rp_q    <= 1'b0;
            wb_q    <= 1'b1;
            bi_q    <= 1'b1;
            oe_q    <= 1'b0;
        end else begin
            cs1_q   <= {battery_below_min, vcc_below_battery, vcc_below_switchover};
            cs2_q   <= cs1_q;
            state_q <= state_d;
            rec_q   <= rec_d;
            week_q  <= week_d;
            pend_q  <= pend_d;
            irq_q   <= irq_d;
            bk_q    <= bk_d;
            sd_q    <= sd_d;
            lp_q    <= lp_d;
            rp_q    <= rp_d;
            wb_q    <= wb_d;
            bi_q    <= bi_d;
            oe_q    <= oe_d;
        end
    end

    // gpio control: pins grounded and inputs frozen unless core powered
    assign gif.dir       = gpio_dir;
    assign gif.out_val   = gpio_out_val;
    assign gif.force_low = !lp_q;

    psm_gpio u_gpio (
        .sys_clk (sys_clk),
        .reset   (reset),
        .ctl     (gif.gp),
        .pin_i   (gpio_pin_i),
        .pin_o   (gpio_pin_o),
        .pin_oe  (gpio_pin_oe)
    );

    assign gpio_in_val    = gif.in_val;
    assign irq_n_o        = 1'b0;       // open drain: only pulls low
    assign irq_n_oe       = oe_q;
    assign backup_mode    = bk_q;
    assign shutdown       = sd_q;
    assign logic_power_en = lp_q;
    assign rtc_power_en   = rp_q;
    assign write_block    = wb_q;
    assign bus_inactive   = bi_q;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    // supply mode transitions and power domains
    backup_entry_a: assert property (
        (state_q == PSM_NORMAL && switchover_threshold && vbb && !blow) |=> backup_mode)
        else $error("backup not entered on supply failure");
    backup_exit_a: assert property (
        (state_q == PSM_BACKUP && !vbb && !(switchover_threshold && blow)) |=> (!backup_mode && bus_inactive))
        else $error("backup not left when vcc above battery");
    rtc_only_a: assert property (
        backup_mode |-> (rtc_power_en && !logic_power_en))
        else $error("backup power domains wrong");
    rtc_kept_a: assert property (
        (backup_mode && !(switchover_threshold && blow)) |=> rtc_power_en)
        else $error("rtc lost power in backup");
    // write and bus hold-offs after backup, and shutdown with no supply
    write_hold_a: assert property (
        $fell(backup_mode) |-> write_block[*4])
        else $error("writes accepted too soon after backup");
    bus_quiet_a: assert property (
        (backup_mode || (state_q == PSM_RECOVER && 32'(rec_q) < BUS_QUIET_CYCLES))
        |-> bus_inactive)
        else $error("bus active during hold-off");
    bus_release_a: assert property (
        $fell(bus_inactive) |-> (32'($past(rec_q)) >= BUS_QUIET_CYCLES - 1
                                 || state_q == PSM_NORMAL))
        else $error("bus released before hold-off");
    shutdown_a: assert property (
        (switchover_threshold && blow) |=> (shutdown && !rtc_power_en && !logic_power_en))
        else $error("no shutdown with both supplies absent");
    // battery check interrupt and weekly recheck
    batt_irq_a: assert property (
        (chk_now && battery_check_enable && blow) |=> irq_q)
        else $error("battery low interrupt missing");
    irq_hold_a: assert property (
        (irq_q && !irq_source_read) |=> irq_q)
        else $error("interrupt dropped without buffer read");
    week_wrap_a: assert property (
        (week_wrap && battery_check_enable && state_q != PSM_OFF) |=> (week_q == '0))
        else $error("week counter failed to wrap");
    // rtc ticks keep the weekly interval running in backup
    week_backup_a: assert property (
        (state_q == PSM_BACKUP && battery_check_enable && rtc_second_tick && !week_wrap)
        |=> (week_q == $past(week_q) + 1'b1))
        else $error("week count stalled in backup");
endmodule
`default_nettype wire

/* verif/psm_host_model.sv */
// host model: reads the interrupt source buffer once the bus may be used
`timescale 1ns/1ps
`default_nettype none
module psm_host_model #(
    parameter int READ_DELAY = 4           // cycles from irq seen to read
) (
    input  wire logic sys_clk,             // system clock
    input  wire logic irq_line_n,          // resolved irq line, pulled up
    input  wire logic bus_inactive,        // device bus held off
    input  wire logic enable,              // bench lets the host act
    output var  logic irq_source_read      // one-cycle read pulse
);
    int wait_q = 0;                        // cycles irq seen with bus usable
    initial irq_source_read = 1'b0;
    // wait for the bus to come alive, then read the buffer once
    always @(posedge sys_clk) begin
        irq_source_read <= 1'b0;
        if (enable && !irq_line_n && !bus_inactive && !irq_source_read) begin
            wait_q <= wait_q + 1;
            if (wait_q >= READ_DELAY) begin
                irq_source_read <= 1'b1;
                wait_q          <= 0;
            end
        end else begin
            wait_q <= 0;
        end
    end
endmodule
`default_nettype wire

/* verif/psm_top_bench.sv */
// self-checking bench for the supply switchover monitor
`timescale 1ns/1ps
`default_nettype none
module psm_top_bench;
    import psm_pkg::*;
    localparam int WP = 10;                 // shortened write hold-off
    localparam int BQ = 20;                 // shortened bus hold-off
    localparam int WK = 6;                  // shortened weekly interval
    logic       sys_clk = 1'b0;             // 40 MHz clock
    logic       reset   = 1'b1;             // held 20 cycles
    logic       switchover_threshold = 1'b1, vbb = 1'b1;     // vcc comparators, no supply yet
    logic       blow = 1'b1, ena = 1'b0;    // battery low, check enable
    logic [1:0] gdir = 2'h0, gout = 2'h0;   // gpio direction and values
    logic [1:0] gpin = 2'h0;                // gpio pin levels in
    logic       rtc_t = 1'b0;               // rtc second tick
    logic [1:0] pin_o, pin_oe, in_val;      // gpio outputs
    logic       irq_n_o, irq_n_oe, irq_rd;  // irq pin and host read
    logic       backup, shut, lpe, rpe;     // supply mode outputs
    logic       wblk, bidle;                // write and bus hold-offs
    wire        irq_line_n = irq_n_oe ? irq_n_o : 1'b1; // pulled-up line
    int         mismatches = 0, checks = 0;
    int         n;

    always #12.5 sys_clk = ~sys_clk;

    psm_top #(.BUS_QUIET_CYCLES(BQ), .WP_RECOVER_CYCLES(WP), .WEEK_TICKS(WK)) i_dut (
        .sys_clk(sys_clk), .reset(reset), .vcc_below_switchover(switchover_threshold),
        .vcc_below_battery(vbb), .battery_below_min(blow), .rtc_second_tick(rtc_t),
        .battery_check_enable(ena), .irq_source_read(irq_rd), .gpio_dir(gdir),
        .gpio_out_val(gout), .gpio_pin_i(gpin), .gpio_pin_o(pin_o),
        .gpio_pin_oe(pin_oe), .gpio_in_val(in_val), .irq_n_o(irq_n_o),
        .irq_n_oe(irq_n_oe), .backup_mode(backup), .shutdown(shut),
        .logic_power_en(lpe), .rtc_power_en(rpe), .write_block(wblk),
        .bus_inactive(bidle));

    psm_host_model i_host (.sys_clk(sys_clk), .irq_line_n(irq_line_n),
        .bus_inactive(bidle), .enable(1'b1), .irq_source_read(irq_rd));

    // compare and count
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // let edges pass, then sample settled outputs
    task automatic tick(input int k);
        repeat (k) @(posedge sys_clk);
        #1;
    endtask

    // drive the three supply comparators at an edge
    task automatic supply(input logic a, input logic b, input logic c);
        @(posedge sys_clk);
        switchover_threshold  <= a;
        vbb  <= b;
        blow <= c;
    endtask

    // from shutdown: power returns, hold-offs counted, power-up battery check
    task automatic t_powerup(input logic low, input logic en, input logic exp_irq);
        int k;
        @(posedge sys_clk);
        ena <= en;
        supply(1'b1, 1'b1, low);
        supply(1'b0, 1'b0, low);
        for (n = 0; n < 10 && lpe !== 1'b1; n++) tick(1);
        check({lpe, rpe, shut, backup, wblk, bidle}, 6'h33);
        for (n = 0; n < 40 && wblk !== 1'b0; n++) tick(1);
        check(n >= WP - 2 && n <= WP + 2, 1'b1);
        check(bidle, 1'b1);
        for (k = n; k < 60 && bidle !== 1'b0; k++) tick(1);
        check(k >= BQ - 2 && k <= BQ + 2, 1'b1);
        tick(2);
        check(irq_n_oe, exp_irq);
        for (n = 0; n < 12 && irq_n_oe !== 1'b0; n++) tick(1);
        check(irq_n_oe, 1'b0);
    endtask

    // gpio use, backup entry conditions, frozen inputs, exit
    task automatic t_backup();
        @(posedge sys_clk);
        gdir <= 2'h1;
        gout <= 2'h1;
        gpin <= 2'h2;
        tick(5);
        check({pin_oe, pin_o, in_val}, 6'h16);
        supply(1'b1, 1'b0, 1'b0);
        tick(6);
        check(backup, 1'b0);
        supply(1'b0, 1'b1, 1'b0);
        tick(6);
        check(backup, 1'b0);
        supply(1'b1, 1'b1, 1'b0);
        for (n = 0; n < 8 && backup !== 1'b1; n++) tick(1);
        tick(2);
        check({backup, lpe, rpe, shut, irq_n_oe}, 5'h14);
        check({pin_oe, pin_o}, 4'hC);
        @(posedge sys_clk);
        gpin  <= 2'h1;
        rtc_t <= 1'b1;
        @(posedge sys_clk);
        rtc_t <= 1'b0;
        tick(5);
        check(in_val, 2'h2);
        supply(1'b1, 1'b0, 1'b0);
        for (n = 0; n < 8 && backup !== 1'b0; n++) tick(1);
        check({backup, lpe, wblk, bidle}, 4'h7);
        for (n = 0; n < 60 && bidle !== 1'b0; n++) tick(1);
        tick(4);
        check({pin_oe, pin_o, in_val}, 6'h14);
    endtask

    // weekly recheck from rtc ticks: interrupt again only while still low
    task automatic t_weekly(input logic low, input logic exp_irq);
        supply(1'b0, 1'b0, low);
        tick(4);
        for (n = 0; n < WK; n++) begin
            @(posedge sys_clk);
            rtc_t <= 1'b1;
            @(posedge sys_clk);
            rtc_t <= 1'b0;
            #1;
            if (n < WK - 1) check(irq_n_oe, 1'b0);
        end
        check(irq_n_oe, exp_irq);
        for (n = 0; n < 12 && irq_n_oe !== 1'b0; n++) tick(1);
        check(irq_n_oe, 1'b0);
    endtask

    // both supplies absent: nothing powered
    task automatic t_shutdown();
        supply(1'b1, 1'b1, 1'b1);
        tick(6);
        check({shut, rpe, lpe, backup}, 4'h8);
    endtask

    // report counts and the verdict, then stop
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        tick(19);
        check({shut, wblk, bidle, lpe, rpe, irq_n_oe, backup, pin_oe[0]}, 8'hE0);
        @(posedge sys_clk);
        reset <= 1'b0;
        tick(6);
        check({shut, irq_n_o}, 2'h2);
        t_powerup(1'b1, 1'b1, 1'b1);
        t_weekly(1'b1, 1'b1);
        t_weekly(1'b0, 1'b0);
        t_backup();
        t_shutdown();
        t_powerup(1'b0, 1'b1, 1'b0);
        t_shutdown();
        t_powerup(1'b1, 1'b0, 1'b0);
        finish_test();
    end

    // cut a hang short
    initial begin
        repeat (20000) @(posedge sys_clk);
        mismatches++;
        $display("BAD %0t watchdog expired", $time);
        finish_test();
    end
endmodule
`default_nettype wire
